// ===== rcr_cfg.svh
/*
  constants for the clock-calendar control register block.
  assumes inclusion by bare name; definitions only.
*/
`ifndef RCR_CFG_SVH
`define RCR_CFG_SVH
`define RCR_ADDR_W        4
`define RCR_OFF_CTRL      4'h0
`define RCR_OFF_TIME_WR   4'h4
`define RCR_OFF_STROBE    4'h8
`define RCR_CAL_HI        25
`define RCR_CAL_LO        16
`define RCR_CAL_MID       24
`define RCR_CAL_W         10
`define RCR_CAL_SPLIT     8
`define RCR_TRIM_ONE      10'h001
`define RCR_BIT_ON        15
`define RCR_BIT_IDLE      13
`define RCR_BIT_SEL       7
`define RCR_BIT_RUN       6
`define RCR_BIT_WREN      3
`define RCR_BIT_SYNC      2
`define RCR_BIT_HALF      1
`define RCR_BIT_OE        0
`define RCR_SEC_HI        14
`define RCR_SEC_LO        8
`define RCR_STB_UNLOCK    0
`define RCR_STB_LOCK      1
`define RCR_ZERO32        32'h0000_0000
`define RCR_CAL_RST       10'h000
`endif

// ===== rcr_pkg.sv
/*
  types for the clock-calendar control register block.
  assumes rcr_cfg.svh is compiled alongside.
*/
package rcr_pkg;
  typedef enum logic [1:0] {RCR_IDLE, RCR_ACK} rcr_bus_st_t;

  typedef struct packed {
    logic [9:0] cal;
    logic       on;
    logic       idle_stop;
    logic       output_source_select;
    logic       write_unlock;
    logic       output_pin_enable;
  } rcr_ctrl_t;

  typedef struct packed {
    logic        seq_enabled;
    logic        trim_pending;
    logic        trim_add;
    logic [9:0]  trim_count;
  } rcr_trim_t;

  typedef struct packed {
    rcr_bus_st_t bus_st;
    logic [31:0] rdata;
    logic        waitreq;
    rcr_ctrl_t   ctrl;
    logic        run_s1;
    logic        run_s2;
    logic        sync_s1;
    logic        sync_s2;
    logic        half_s1;
    logic        half_s2;
    logic        idle_s1;
    logic        idle_s2;
    logic        alarm_s1;
    logic        alarm_s2;
    logic        secclk_s1;
    logic        secclk_s2;
    logic        min_s1;
    logic        min_s2;
    logic        min_d;
    logic        half_clear;
    logic        rtc_pin;
    logic        rtc_pin_oe;
    logic        pb_gate_en;
    logic        module_on;
    rcr_trim_t   trim;
    logic        trim_add_pulse;
    logic        trim_drop_pulse;
  } rcr_state_t;
endpackage

// ===== rcr_ctrl.sv
/*
  clock-calendar control register: avalon-mm slave with one wait state,
  write protection of the enable bit, drift trim pulse generation,
  idle-mode bus clock gating and output pin source select.
  the control word sits at one offset, the time write port at a second
  and the unlock sequence strobe at a third; other offsets read zero.
  assumes the timekeeping core supplies running, sync, half-second,
  idle, alarm, seconds-clock and minute levels from its own clock, so
  every one of them passes two flops here before any logic reads it.
  assumes the core counts the trim pulses into its prescaler and
  clears its half-second flag on the clear pulse.
  assumes power-on reset alone drives arst_n; no other reset source
  reaches this block, so the control word survives them.
  assumes the bus master holds each request until waitrequest is low.
*/
// Chosen here: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ns
`include "rcr_cfg.svh"

module rcr_ctrl (
  input  wire logic                     core_clk,
  input  wire logic                     arst_n,
  input  wire logic [`RCR_ADDR_W-1:0]   avs_address,
  input  wire logic                     avs_read,
  input  wire logic                     avs_write,
  input  wire logic [31:0]              avs_writedata,
  input  wire logic [3:0]               avs_byteenable,
  output logic [31:0]                   avs_readdata,
  output logic                          avs_waitrequest,
  input  wire logic                     clk_src_running,
  input  wire logic                     rollover_sync,
  input  wire logic                     half_second,
  input  wire logic                     idle_mode,
  input  wire logic                     alarm_pulse,
  input  wire logic                     seconds_clock,
  input  wire logic                     minute_tick,
  output logic                          rtc_pin_out,
  output logic                          rtc_pin_oe,
  output logic                          pb_clk_gate_en,
  output logic                          module_enable,
  output logic                          half_second_clear,
  output logic                          trim_add_pulse,
  output logic                          trim_drop_pulse
);

  rcr_pkg::rcr_state_t st_r;
  rcr_pkg::rcr_state_t st_nxt;

  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  function automatic logic [31:0] ctrl_read(input rcr_pkg::rcr_state_t s);
    logic [31:0] v;
    v = `RCR_ZERO32;
    v[`RCR_CAL_HI:`RCR_CAL_LO] = s.ctrl.cal;
    v[`RCR_BIT_ON]   = s.ctrl.on;
    v[`RCR_BIT_IDLE] = s.ctrl.idle_stop;
    v[`RCR_BIT_SEL]  = s.ctrl.output_source_select;
    v[`RCR_BIT_RUN]  = s.run_s2;
    v[`RCR_BIT_WREN] = s.ctrl.write_unlock;
    v[`RCR_BIT_SYNC] = s.sync_s2;
    v[`RCR_BIT_HALF] = s.half_s2;
    v[`RCR_BIT_OE]   = s.ctrl.output_pin_enable;
    ctrl_read = v;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // address decode

  function automatic logic hits_ctrl(input logic [`RCR_ADDR_W-1:0] a);
    hits_ctrl = (a == `RCR_OFF_CTRL);
  endfunction

  function automatic logic hits_time(input logic [`RCR_ADDR_W-1:0] a);
    hits_time = (a == `RCR_OFF_TIME_WR);
  endfunction

  function automatic logic hits_strobe(input logic [`RCR_ADDR_W-1:0] a);
    hits_strobe = (a == `RCR_OFF_STROBE);
  endfunction

  // unmapped offsets read zero
  function automatic logic [31:0] bus_read(input logic [`RCR_ADDR_W-1:0] a,
                                           input rcr_pkg::rcr_state_t    s);
    logic [31:0] v;
    v = `RCR_ZERO32;
    if (hits_ctrl(a)) begin
      v = ctrl_read(s);
    end else if (hits_strobe(a)) begin
      v[`RCR_STB_UNLOCK] = s.trim.seq_enabled;
    end
    bus_read = v;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // write path

  // lanes without a strobe keep their fields
  function automatic rcr_pkg::rcr_ctrl_t ctrl_write(input rcr_pkg::rcr_ctrl_t c,
                                                    input logic [31:0]       wv,
                                                    input logic [31:0]       m,
                                                    input logic              seq_en);
    rcr_pkg::rcr_ctrl_t n;
    n = c;
    if (m[`RCR_CAL_HI]) begin
      n.cal[`RCR_CAL_W-1:`RCR_CAL_SPLIT] = wv[`RCR_CAL_HI:`RCR_CAL_MID];
    end
    if (m[`RCR_CAL_LO]) begin
      n.cal[`RCR_CAL_SPLIT-1:0] = wv[`RCR_CAL_MID-1:`RCR_CAL_LO];
    end
    if (m[`RCR_BIT_ON]) begin
      // enable only moves while unlocked
      if (c.write_unlock) begin
        n.on = wv[`RCR_BIT_ON];
      end
      n.idle_stop = wv[`RCR_BIT_IDLE];
    end
    if (m[`RCR_BIT_OE]) begin
      n.output_source_select = wv[`RCR_BIT_SEL];
      n.output_pin_enable    = wv[`RCR_BIT_OE];
      // clearing always works, setting needs the sequence
      if (!wv[`RCR_BIT_WREN]) begin
        n.write_unlock = 1'b0;
      end else if (seq_en) begin
        n.write_unlock = 1'b1;
      end
    end
    ctrl_write = n;
  endfunction

  // any strobe on the seconds lane counts as a seconds write
  function automatic logic seconds_hit(input logic [31:0] m);
    seconds_hit = m[`RCR_SEC_HI] || m[`RCR_SEC_LO];
  endfunction

  // bit0 enables the unlock sequence, bit1 disables it
  function automatic logic strobe_next(input logic cur, input logic [31:0] wv);
    strobe_next = cur;
    if (wv[`RCR_STB_UNLOCK]) begin
      strobe_next = 1'b1;
    end else if (wv[`RCR_STB_LOCK]) begin
      strobe_next = 1'b0;
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // trim engine

  // rising edge of the synchronised minute level
  function automatic logic minute_edge(input rcr_pkg::rcr_state_t s);
    minute_edge = s.min_s2 && !s.min_d;
  endfunction

  // magnitude of the signed trim; the most negative code gives 512
  function automatic logic [`RCR_CAL_W-1:0] trim_mag(input logic [`RCR_CAL_W-1:0] cal);
    if (cal[`RCR_CAL_W-1]) begin
      trim_mag = ~cal + `RCR_TRIM_ONE;
    end else begin
      trim_mag = cal;
    end
  endfunction

  // a load restarts the count; otherwise each cycle spends one pulse
  function automatic rcr_pkg::rcr_trim_t trim_next(input rcr_pkg::rcr_trim_t          t,
                                                   input logic                        load,
                                                   input logic [`RCR_CAL_W-1:0]       cal);
    rcr_pkg::rcr_trim_t n;
    n = t;
    if (load) begin
      n.trim_pending = 1'b1;
      n.trim_add     = !cal[`RCR_CAL_W-1];
      n.trim_count   = trim_mag(cal);
    end else if (t.trim_pending) begin
      n.trim_count = t.trim_count - `RCR_TRIM_ONE;
      if (t.trim_count == `RCR_TRIM_ONE) begin
        n.trim_pending = 1'b0;
      end
    end
    trim_next = n;
  endfunction

  // pulse pair {add, drop} spent in this cycle
  function automatic logic [1:0] trim_pulses(input rcr_pkg::rcr_trim_t t, input logic load);
    trim_pulses = 2'b00;
    if (!load && t.trim_pending) begin
      if (t.trim_add) begin
        trim_pulses = 2'b10;
      end else begin
        trim_pulses = 2'b01;
      end
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // pin and gate

  // pin stays low while the output is disabled
  function automatic logic pin_level(input rcr_pkg::rcr_ctrl_t c,
                                     input logic               sec,
                                     input logic               alarm);
    if (!c.output_pin_enable) begin
      pin_level = 1'b0;
    end else if (c.output_source_select) begin
      pin_level = sec;
    end else begin
      pin_level = alarm;
    end
  endfunction

  // bus clock stays on unless idle-stop is set and the chip idles
  function automatic logic gate_level(input logic idle_stop, input logic idle);
    gate_level = !(idle_stop && idle);
  endfunction

  //////////////////////////////////////////////////////////////////////////////

  always_comb begin
    logic [31:0] m;
    logic [31:0] wv;
    logic        acc;
    logic        min_edge;
    logic        trim_load;
    m        = lane_mask(avs_byteenable);
    wv       = avs_writedata & m;
    acc      = avs_read || avs_write;
    min_edge = minute_edge(st_r);
    trim_load = min_edge && st_r.ctrl.on && (st_r.ctrl.cal != `RCR_CAL_RST);
    st_nxt   = st_r;

    // two-flop synchronisers on every level from the core
    st_nxt.run_s1    = clk_src_running;
    st_nxt.run_s2    = st_r.run_s1;
    st_nxt.sync_s1   = rollover_sync;
    st_nxt.sync_s2   = st_r.sync_s1;
    st_nxt.half_s1   = half_second;
    st_nxt.half_s2   = st_r.half_s1;
    st_nxt.idle_s1   = idle_mode;
    st_nxt.idle_s2   = st_r.idle_s1;
    st_nxt.alarm_s1  = alarm_pulse;
    st_nxt.alarm_s2  = st_r.alarm_s1;
    st_nxt.secclk_s1 = seconds_clock;
    st_nxt.secclk_s2 = st_r.secclk_s1;
    st_nxt.min_s1    = minute_tick;
    st_nxt.min_s2    = st_r.min_s1;
    st_nxt.min_d     = st_r.min_s2;

    st_nxt.half_clear      = 1'b0;
    st_nxt.trim_add_pulse  = 1'b0;
    st_nxt.trim_drop_pulse = 1'b0;

    // bus: one wait cycle, then ack with data
    case (st_r.bus_st)
      rcr_pkg::RCR_IDLE: begin
        st_nxt.waitreq = 1'b1;
        if (acc) begin
          st_nxt.bus_st  = rcr_pkg::RCR_ACK;
          st_nxt.waitreq = 1'b0;
          st_nxt.rdata   = `RCR_ZERO32;
          // read data is captured on the taking edge and stands until the next transfer is taken
          if (avs_read) begin
            st_nxt.rdata = bus_read(avs_address, st_r);
          end
          if (avs_write) begin
            if (hits_ctrl(avs_address)) begin
              st_nxt.ctrl = ctrl_write(st_r.ctrl, wv, m, st_r.trim.seq_enabled);
            end else if (hits_time(avs_address)) begin
              st_nxt.half_clear = seconds_hit(m);
            end else if (hits_strobe(avs_address)) begin
              st_nxt.trim.seq_enabled = strobe_next(st_r.trim.seq_enabled, wv);
            end
          end
        end
      end
      rcr_pkg::RCR_ACK: begin
        st_nxt.bus_st  = rcr_pkg::RCR_IDLE;
        st_nxt.waitreq = 1'b1;
      end
      default: begin
        st_nxt.bus_st  = rcr_pkg::RCR_IDLE;
        st_nxt.waitreq = 1'b1;
      end
    endcase

    // trim engine: one pulse per cycle after each minute boundary seen while on with a nonzero trim
    // st_nxt.trim carries a sequence strobe written in this same cycle
    st_nxt.trim = trim_next(st_nxt.trim, trim_load, st_r.ctrl.cal);
    {st_nxt.trim_add_pulse, st_nxt.trim_drop_pulse} = trim_pulses(st_r.trim, trim_load);

    // outputs, each registered once more
    st_nxt.module_on  = st_r.ctrl.on;
    st_nxt.pb_gate_en = gate_level(st_r.ctrl.idle_stop, st_r.idle_s2);
    st_nxt.rtc_pin    = pin_level(st_r.ctrl, st_r.secclk_s2, st_r.alarm_s2);
    st_nxt.rtc_pin_oe = st_r.ctrl.output_pin_enable;
  end

  //////////////////////////////////////////////////////////////////////////////

  // arst_n is the power-on reset only
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r            <= '0;
      st_r.bus_st     <= rcr_pkg::RCR_IDLE;
      st_r.waitreq    <= 1'b1;
      st_r.pb_gate_en <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign avs_readdata      = st_r.rdata;
  assign avs_waitrequest   = st_r.waitreq;
  assign rtc_pin_out       = st_r.rtc_pin;
  assign rtc_pin_oe        = st_r.rtc_pin_oe;
  assign pb_clk_gate_en    = st_r.pb_gate_en;
  assign module_enable     = st_r.module_on;
  assign half_second_clear = st_r.half_clear;
  assign trim_add_pulse    = st_r.trim_add_pulse;
  assign trim_drop_pulse   = st_r.trim_drop_pulse;

endmodule

// ===== rcr_ctrl_chk.sv
/* port assertions for the clock-calendar control register block.
   assumes a bind from the bench top file and rcr_cfg.svh alongside. */
`timescale 1ns/1ns
module rcr_ctrl_chk (
  input wire logic        core_clk,
  input wire logic        arst_n,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        idle_mode,
  input wire logic        rtc_pin_out,
  input wire logic        rtc_pin_oe,
  input wire logic        pb_clk_gate_en,
  input wire logic        module_enable,
  input wire logic        half_second_clear,
  input wire logic        trim_add_pulse,
  input wire logic        trim_drop_pulse
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////////////////////////
  a_ack_next: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("ack late");
  a_ack_single: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("ack long");
  a_unimpl_zero: assert property (avs_read && !avs_waitrequest && avs_address == 4'h0 |->
    (avs_readdata & 32'hfc00_5f30) == 32'h0) else $error("reserved bits set");
  a_pin_gated: assert property (!rtc_pin_oe |-> !rtc_pin_out) else $error("pin driven");
  a_gate_idle: assert property (!idle_mode [*5] |-> pb_clk_gate_en)
    else $error("gate off");
  a_en_hold: assert property (!avs_write [*4] |-> $stable(module_enable))
    else $error("enable moved");
  a_trim_excl: assert property (!(trim_add_pulse && trim_drop_pulse))
    else $error("both trims");
  a_half_pulse: assert property (half_second_clear |=> !half_second_clear)
    else $error("clear long");
  cover property (avs_read && !avs_waitrequest);
  cover property (trim_add_pulse);
  cover property (trim_drop_pulse);
endmodule

// ===== rcr_ctrl_tb.sv
/* self-checking bench for rcr_ctrl over avalon-mm.
   assumes rcr_cfg.svh and the checker are compiled alongside. */
`timescale 1ns/1ns
module rcr_ctrl_tb;
  logic        core_clk, arst_n, rd, wr, run, sync, half, idle, alarm, secs, minute;
  logic [3:0]  addr, be;
  logic [31:0] wd, rdat, q;
  logic        wreq, pin, oe, gate, en, hclr, addp, dropp;
  int          miscompares = 0, total_checks = 0, cycles = 0, n_add, n_drop, n_hclr;
  rcr_ctrl rcr_ctrl_inst (.core_clk(core_clk), .arst_n(arst_n), .avs_address(addr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be),
    .avs_readdata(rdat), .avs_waitrequest(wreq), .clk_src_running(run),
    .rollover_sync(sync), .half_second(half), .idle_mode(idle), .alarm_pulse(alarm),
    .seconds_clock(secs), .minute_tick(minute), .rtc_pin_out(pin), .rtc_pin_oe(oe),
    .pb_clk_gate_en(gate), .module_enable(en), .half_second_clear(hclr),
    .trim_add_pulse(addp), .trim_drop_pulse(dropp));
  ////////////////////////////////////////////////////////////
  task automatic complete_run();
    if (miscompares == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one transfer, held until waitrequest is seen low, then an idle cycle
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] b = 4'hf);
    int k = 0;
    rd <= !w; wr <= w; addr <= a; wd <= d; be <= b;
    do begin @(posedge core_clk); k++; end while (wreq !== 1'b0 && k < 40);
    q = rdat; rd <= 1'b0; wr <= 1'b0;
    if (k >= 40) miscompares++;
    @(posedge core_clk);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic t_regs();
    bus(0, 4'h0, 0); chk("ctrl_reset", 32'h0, q);
    bus(1, 4'h0, 32'hffff_ffff); bus(0, 4'h0, 0); chk("ctrl_locked", 32'h03ff_2081, q);
    bus(0, 4'hc, 0); chk("unmapped", 32'h0, q);
    bus(1, 4'h8, 32'h1); bus(0, 4'h8, 0); chk("seq_on", 32'h1, q[0]);
    bus(1, 4'h0, 32'h8); bus(1, 4'h0, 32'h8000); bus(1, 4'h0, 32'h0);
    bus(0, 4'h0, 0); chk("ctrl_on", 32'h8000, q);
    chk("enable_out", 32'h1, en);
  endtask
  task automatic t_pins();
    secs <= 1'b1; bus(1, 4'h0, 32'h81); wt(5); chk("pin_sec", 32'h3, {oe, pin});
    bus(1, 4'h0, 32'h1); wt(5); chk("pin_alarm_lo", 32'h2, {oe, pin});
    alarm <= 1'b1; wt(5); chk("pin_alarm_hi", 32'h3, {oe, pin});
    bus(1, 4'h0, 32'h0); wt(5); chk("pin_off", 32'h0, {oe, pin});
    idle <= 1'b1; bus(1, 4'h0, 32'h2000); wt(5); chk("gate_idle", 32'h0, gate);
    bus(1, 4'h0, 32'h0); wt(5); chk("gate_run", 32'h1, gate);
  endtask
  task automatic t_status();
    run <= 1'b1; sync <= 1'b1; half <= 1'b1; wt(5);
    bus(0, 4'h0, 0); chk("status_on", 32'h46, q & 32'h46);
    n_hclr = 0; bus(1, 4'h4, 32'h1, 4'h1); wt(5); chk("hclr_lane0", 32'h0, n_hclr);
    bus(1, 4'h4, 32'h100, 4'h2); wt(5); chk("hclr_lane1", 32'h1, n_hclr);
    run <= 1'b0; wt(5); bus(0, 4'h0, 0); chk("status_off", 32'h0, q & 32'h40);
  endtask
  task automatic t_trim(input logic [9:0] c, input int na, input int nd);
    bus(1, 4'h8, 32'h1); bus(1, 4'h0, 32'h8);
    bus(1, 4'h0, {6'h0, c, 16'h8008}); n_add = 0; n_drop = 0;
    minute <= 1'b1; wt(4); minute <= 1'b0; wt(600);
    chk("trim_add", na, n_add);
    chk("trim_drop", nd, n_drop);
  endtask
  ////////////////////////////////////////////////////////////
  always @(posedge core_clk) begin
    cycles++;
    if (addp === 1'b1) n_add++;
    if (dropp === 1'b1) n_drop++;
    if (hclr === 1'b1) n_hclr++;
    if (cycles > 8000) begin
      miscompares++;
      complete_run();
    end
  end
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  initial begin
    {arst_n, rd, wr, run, sync, half, idle, alarm, secs, minute} = '0;
    addr = 4'h0; be = 4'hf; wd = 32'h0;
    repeat (8) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    t_regs();
    t_pins();
    t_status();
    t_trim(10'h003, 3, 0);
    t_trim(10'h1ff, 511, 0);
    t_trim(10'h3ff, 0, 1);
    t_trim(10'h200, 0, 512);
    t_trim(10'h000, 0, 0);
    complete_run();
  end
endmodule
bind rcr_ctrl rcr_ctrl_chk rcr_ctrl_chk_inst (.core_clk(core_clk), .arst_n(arst_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .idle_mode(idle_mode),
  .rtc_pin_out(rtc_pin_out), .rtc_pin_oe(rtc_pin_oe), .pb_clk_gate_en(pb_clk_gate_en),
  .module_enable(module_enable), .half_second_clear(half_second_clear),
  .trim_add_pulse(trim_add_pulse), .trim_drop_pulse(trim_drop_pulse));
